// File: rtl/stcu_trap_unit.v
// supervisor trap handling: pending, reason, vector, status, entry and return
//
// Functional notes
// - pending register shows software bit 1, timer bit 5, external bit 9.
// - interrupt trap sets reason top bit and interrupt number in low bits.
// - interrupt number equals its pending bit position: 1, 5, 9.
// - exception trap clears reason top bit and writes exception code.
// - reason holds 63-bit code in 62:0, legal values only, flag at 63.
// - legal exception codes 0-3,5-8,12,13,15; others are reserved.
// - vector mode in bits 1:0; 0 direct, 1 vectored, others reserved.
// - vector base stored in 63:2; low two address bits read zero.
// - direct jumps to base; vectored interrupts to base plus four times cause.
// - all external interrupts use cause 9, sharing one vector entry.
// - trap entry copies enable into prior enable, then clears enable.
// - trap entry saves pc to exception pc and jumps to vector.
// - trap entry records prior privilege in status bit 8.
// - software setting enable in handler re-enables interrupts at once.
// - return restores privilege, enable from prior enable, pc from exception pc.
// - status holds enable bit 1, prior enable bit 5, prior privilege bit 8.
// - interrupt taken only with global enable and matching individual enable.
// - priority among pending enabled interrupts: external, software, timer.
`timescale 1ns/1ps
`include "stcu_regs.vh"

module stcu_trap_unit
(
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // csr access from the pipeline
  input wire csr_wr,
  input wire [11:0] csr_addr,
  input wire [63:0] csr_wdata,
  output reg [63:0] csr_rdata,
  output wire csr_hit,
  // interrupt sources (levels)
  input wire timer_irq_in,
  input wire external_irq_in,
  // exception and instruction events from the pipeline
  input wire exc_valid,
  input wire [62:0] exc_code,
  input wire [63:0] cur_pc,
  input wire cur_priv_super,
  input wire supervisor_return,
  input wire irq_accept,
  // to the pipeline
  output wire irq_request,
  output wire [62:0] irq_cause,
  output reg redirect_ff,
  output reg [63:0] redirect_pc_ff,
  output reg priv_super_ff
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg ie_ff;
  reg pie_ff;
  reg pp_ff;
  reg [63:0] enable_ff;
  reg soft_irq_pending_ff;
  reg [63:0] reason_ff;
  reg [61:0] base_ff;
  reg [1:0] mode_ff;
  reg [63:0] epc_ff;

  wire [63:0] pending_view;
  wire [63:0] status_view;
  wire [63:0] active;
  wire wr_status;
  wire wr_enable;
  wire wr_vector;
  wire wr_epc;
  wire wr_reason;
  wire wr_pending;
  wire take_irq;
  wire take_exc;
  wire take_trap;
  wire exc_legal;
  wire [63:0] base_addr;
  wire [63:0] trap_reason;
  wire [63:0] trap_target;
  wire mode_legal;
  wire irq_code_legal;
  wire reason_wr_ok;

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  // timer and external come straight from their sources; only software is stored
  assign pending_view = {54'h0, external_irq_in, 3'h0, timer_irq_in, 3'h0,
                         soft_irq_pending_ff, 1'b0};
  assign status_view = {55'h0, pp_ff, 2'h0, pie_ff, 3'h0, ie_ff, 1'b0};
  assign base_addr = {base_ff, 2'h0};

  // ----------------------------------------------------------------
  // csr decode and read
  // ----------------------------------------------------------------
  assign wr_status = csr_wr && (csr_addr == `STCU_ADDR_STATUS);
  assign wr_enable = csr_wr && (csr_addr == `STCU_ADDR_ENABLE);
  assign wr_vector = csr_wr && (csr_addr == `STCU_ADDR_VECTOR);
  assign wr_epc = csr_wr && (csr_addr == `STCU_ADDR_EPC);
  assign wr_reason = csr_wr && (csr_addr == `STCU_ADDR_REASON);
  assign wr_pending = csr_wr && (csr_addr == `STCU_ADDR_PENDING);

  assign csr_hit = (csr_addr == `STCU_ADDR_STATUS) || (csr_addr == `STCU_ADDR_ENABLE) ||
                   (csr_addr == `STCU_ADDR_VECTOR) || (csr_addr == `STCU_ADDR_EPC) ||
                   (csr_addr == `STCU_ADDR_REASON) || (csr_addr == `STCU_ADDR_PENDING);

  always @*
  begin
    case (csr_addr)
      `STCU_ADDR_STATUS: csr_rdata = status_view;
      `STCU_ADDR_ENABLE: csr_rdata = enable_ff;
      `STCU_ADDR_VECTOR: csr_rdata = {base_ff, mode_ff};
      `STCU_ADDR_EPC: csr_rdata = epc_ff;
      `STCU_ADDR_REASON: csr_rdata = reason_ff;
      `STCU_ADDR_PENDING: csr_rdata = pending_view;
      default: csr_rdata = `STCU_RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt selection
  // ----------------------------------------------------------------
  // enable taken live from ie_ff so a handler's write of one acts next cycle
  // only the three implemented lines can qualify; reserved positions stay zero
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1)
    begin : g_line
      if (g == `STCU_IRQ_SOFT || g == `STCU_IRQ_TIMER || g == `STCU_IRQ_EXT)
      begin : g_impl
        assign active[g] = pending_view[g] & enable_ff[g] & ie_ff;
      end
      else
      begin : g_resv
        assign active[g] = 1'b0;
      end
    end
  endgenerate

  assign irq_request = |active;
  // fixed order; the pending bit position doubles as the cause code
  assign irq_cause = active[`STCU_IRQ_EXT] ? `STCU_CAUSE_EXT :
                     active[`STCU_IRQ_SOFT] ? `STCU_CAUSE_SOFT :
                     `STCU_CAUSE_TIMER;

  // ----------------------------------------------------------------
  // exception code legality
  // ----------------------------------------------------------------
  function legal_code;
    input [62:0] code;
    begin
      case (code)
        `STCU_EXC_FETCH_MISALIGN,
        `STCU_EXC_FETCH_FAULT,
        `STCU_EXC_ILLEGAL,
        `STCU_EXC_BREAK,
        `STCU_EXC_LOAD_FAULT,
        `STCU_EXC_STORE_MISALIGN,
        `STCU_EXC_STORE_FAULT,
        `STCU_EXC_UCALL,
        `STCU_EXC_FETCH_PAGE,
        `STCU_EXC_LOAD_PAGE,
        `STCU_EXC_STORE_PAGE: legal_code = 1'b1;
        default: legal_code = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // trap decision and target
  // ----------------------------------------------------------------
  assign exc_legal = legal_code(exc_code);
  // exceptions win over interrupts; reserved codes are folded to illegal instruction
  assign take_exc = exc_valid;
  assign take_irq = irq_accept && irq_request && !exc_valid;
  assign take_trap = take_exc || take_irq;

  assign trap_reason = take_irq ? {1'b1, irq_cause} :
                       {1'b0, exc_legal ? exc_code : `STCU_EXC_ILLEGAL};

  // exceptions always go to base, even in vectored mode
  assign trap_target = (take_irq && mode_ff == `STCU_MODE_VECTORED) ?
                       base_addr + {irq_cause[61:0], 2'h0} : base_addr;

  // ----------------------------------------------------------------
  // status: enable, prior enable, prior privilege
  // ----------------------------------------------------------------
  // trap entry beats return, and both beat a software write in the same cycle
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      ie_ff <= 1'b0;
    else if (take_trap)
      ie_ff <= 1'b0;
    else if (supervisor_return)
      ie_ff <= pie_ff;
    else if (wr_status)
      ie_ff <= csr_wdata[`STCU_ST_IE];
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      pie_ff <= 1'b0;
    else if (take_trap)
      pie_ff <= ie_ff;
    else if (supervisor_return)
      pie_ff <= 1'b1;
    else if (wr_status)
      pie_ff <= csr_wdata[`STCU_ST_PIE];
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      pp_ff <= 1'b0;
    else if (take_trap)
      pp_ff <= priv_super_ff;
    else if (supervisor_return)
      pp_ff <= 1'b0;
    else if (wr_status)
      pp_ff <= csr_wdata[`STCU_ST_PP];
  end

  // ----------------------------------------------------------------
  // enable and software pending
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      enable_ff <= `STCU_RST_WORD;
    else if (wr_enable)
      enable_ff <= csr_wdata & `STCU_IRQ_MASK;
  end

  // timer and external are not stored here; they follow their source levels
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      soft_irq_pending_ff <= 1'b0;
    else if (wr_pending)
      soft_irq_pending_ff <= csr_wdata[`STCU_IRQ_SOFT];
  end

  // ----------------------------------------------------------------
  // trap vector
  // ----------------------------------------------------------------
  assign mode_legal = (csr_wdata[1:0] == `STCU_MODE_DIRECT) || (csr_wdata[1:0] == `STCU_MODE_VECTORED);

  // a reserved mode keeps the old mode, the base is still taken
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      base_ff <= 62'h0;
      mode_ff <= `STCU_MODE_DIRECT;
    end
    else if (wr_vector)
    begin
      base_ff <= csr_wdata[63:2];
      if (mode_legal)
        mode_ff <= csr_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // exception pc
  // ----------------------------------------------------------------
  // software writes drop bits 1:0; a trap saves the pc as the pipeline gives it
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      epc_ff <= `STCU_RST_WORD;
    else if (take_trap)
      epc_ff <= cur_pc;
    else if (wr_epc)
      epc_ff <= {csr_wdata[63:2], 2'h0};
  end

  // ----------------------------------------------------------------
  // trap reason
  // ----------------------------------------------------------------
  // software may only store codes that hardware could have written
  assign irq_code_legal = (csr_wdata[62:0] == `STCU_CAUSE_SOFT) ||
                          (csr_wdata[62:0] == `STCU_CAUSE_TIMER) ||
                          (csr_wdata[62:0] == `STCU_CAUSE_EXT);
  assign reason_wr_ok = csr_wdata[`STCU_REASON_INTR] ? irq_code_legal : legal_code(csr_wdata[62:0]);

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      reason_ff <= `STCU_RST_WORD;
    else if (take_trap)
      reason_ff <= trap_reason;
    else if (wr_reason && reason_wr_ok)
      reason_ff <= csr_wdata;
  end

  // ----------------------------------------------------------------
  // redirect to the pipeline
  // ----------------------------------------------------------------
  // one-cycle pulse; the target pc holds until the next redirect
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      redirect_ff <= 1'b0;
      redirect_pc_ff <= `STCU_RST_WORD;
    end
    else if (take_trap)
    begin
      redirect_ff <= 1'b1;
      redirect_pc_ff <= trap_target;
    end
    else if (supervisor_return)
    begin
      redirect_ff <= 1'b1;
      redirect_pc_ff <= epc_ff;
    end
    else
      redirect_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // privilege
  // ----------------------------------------------------------------
  // tracked here rather than taken from cur_priv_super, which stays unused:
  // the unit's own copy can not disagree with what it saved on entry
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      priv_super_ff <= 1'b1;
    else if (take_trap)
      priv_super_ff <= 1'b1;
    else if (supervisor_return)
      priv_super_ff <= pp_ff;
  end

  wire unused_priv = cur_priv_super;

endmodule

// File: rtl/stcu_regs.vh
// register addresses, field positions, codes and reset values of the supervisor trap unit
`ifndef STCU_REGS_VH
`define STCU_REGS_VH

// csr addresses (own map)
`define STCU_ADDR_STATUS 12'h100
`define STCU_ADDR_ENABLE 12'h104
`define STCU_ADDR_VECTOR 12'h105
`define STCU_ADDR_EPC 12'h141
`define STCU_ADDR_REASON 12'h142
`define STCU_ADDR_PENDING 12'h144

// status fields
`define STCU_ST_IE 1
`define STCU_ST_PIE 5
`define STCU_ST_PP 8

// pending / enable fields
`define STCU_IRQ_SOFT 1
`define STCU_IRQ_TIMER 5
`define STCU_IRQ_EXT 9
`define STCU_IRQ_MASK 64'h0000000000000222

// interrupt cause codes, equal to the pending bit positions
`define STCU_CAUSE_SOFT 63'h1
`define STCU_CAUSE_TIMER 63'h5
`define STCU_CAUSE_EXT 63'h9

// reason register
`define STCU_REASON_INTR 63

// vector modes
`define STCU_MODE_DIRECT 2'h0
`define STCU_MODE_VECTORED 2'h1

// exception codes
`define STCU_EXC_FETCH_MISALIGN 63'h0
`define STCU_EXC_FETCH_FAULT 63'h1
`define STCU_EXC_ILLEGAL 63'h2
`define STCU_EXC_BREAK 63'h3
`define STCU_EXC_LOAD_FAULT 63'h5
`define STCU_EXC_STORE_MISALIGN 63'h6
`define STCU_EXC_STORE_FAULT 63'h7
`define STCU_EXC_UCALL 63'h8
`define STCU_EXC_FETCH_PAGE 63'hC
`define STCU_EXC_LOAD_PAGE 63'hD
`define STCU_EXC_STORE_PAGE 63'hF

// reset values
`define STCU_RST_WORD 64'h0000000000000000

`endif

// File: tb/stcu_pipe_model.sv
// pipeline model that accepts requested interrupts
`timescale 1ns/1ps
module stcu_pipe_model (
  // clock, reset and accept control
  input wire ref_clk, sys_rst, take_en, irq_request,
  // to the trap unit
  output reg irq_accept = 1'b0
);
  // never two accepts in a row: a held accept could take a second trap
  always @(posedge ref_clk)
    irq_accept <= !sys_rst & take_en & irq_request & !irq_accept;
endmodule

// File: tb/stcu_trap_unit_properties.sv
// port assertions for the supervisor trap unit
`timescale 1ns/1ps
module stcu_props (
  // clock and reset
  input wire ref_clk, sys_rst,
  // pipeline side
  input wire exc_valid, supervisor_return, irq_accept, irq_request, redirect_ff, priv_super_ff,
  input wire [62:0] irq_cause,
  input wire [63:0] redirect_pc_ff,
  // csr side
  input wire [11:0] csr_addr,
  input wire [63:0] csr_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire trap = exc_valid | (irq_accept & irq_request);
  sequence s_ret; supervisor_return && !trap; endsequence
  sequence s_epc; csr_addr == 12'h141; endsequence
  property p_trap; trap |=> redirect_ff && priv_super_ff; endproperty
  a_trap: assert property (p_trap) else $error("trap without redirect");
  property p_idle; !trap && !supervisor_return |=> !redirect_ff; endproperty
  a_idle: assert property (p_idle) else $error("redirect without cause");
  property p_mask; irq_accept && irq_request && !exc_valid |=> !irq_request; endproperty
  a_mask: assert property (p_mask) else $error("enable kept on entry");
  property p_ret; s_ret ##0 s_epc |=> redirect_ff && redirect_pc_ff == $past(csr_rdata); endproperty
  a_ret: assert property (p_ret) else $error("return target wrong");
  property p_cause; irq_request |-> irq_cause inside {1, 5, 9}; endproperty
  a_cause: assert property (p_cause) else $error("bad interrupt cause");
  property p_pend; csr_addr == 12'h144 |-> (csr_rdata & ~64'h222) == 0; endproperty
  a_pend: assert property (p_pend) else $error("reserved pending bit set");
  property p_mode; csr_addr == 12'h105 |-> csr_rdata[1:0] < 2; endproperty
  a_mode: assert property (p_mode) else $error("reserved vector mode");
  property p_code; csr_addr == 12'h142 && !csr_rdata[63] |-> csr_rdata[62:0] inside {[0:3], [5:8], 12, 13, 15};
  endproperty
  a_code: assert property (p_code) else $error("illegal exception code");
endmodule
bind stcu_trap_unit stcu_props P (.ref_clk(ref_clk), .sys_rst(sys_rst), .exc_valid(exc_valid),
  .supervisor_return(supervisor_return), .irq_accept(irq_accept), .irq_request(irq_request),
  .redirect_ff(redirect_ff), .priv_super_ff(priv_super_ff), .irq_cause(irq_cause),
  .redirect_pc_ff(redirect_pc_ff), .csr_addr(csr_addr), .csr_rdata(csr_rdata));

// File: tb/tb_top.sv
// testbench: csr access, exceptions, interrupts and return
`timescale 1ns/1ps
module tb_top;
  reg ref_clk = 0, sys_rst = 1, csr_wr = 0, exc_valid = 0, supervisor_return = 0, take_en = 0;
  reg timer_irq_in = 0, external_irq_in = 0, cur_priv_super = 0;
  reg [11:0] csr_addr = 0;
  reg [62:0] exc_code = 0;
  reg [63:0] csr_wdata = 0, cur_pc = 64'h4000;
  wire [63:0] csr_rdata, redirect_pc_ff;
  wire [62:0] irq_cause;
  wire csr_hit, irq_request, irq_accept, redirect_ff, priv_super_ff;
  integer n_fail = 0, check_count = 0, i, c;
  always #12.5 ref_clk = ~ref_clk;
  stcu_trap_unit DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .csr_wr(csr_wr), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata), .csr_hit(csr_hit), .timer_irq_in(timer_irq_in),
    .external_irq_in(external_irq_in), .exc_valid(exc_valid), .exc_code(exc_code), .cur_pc(cur_pc),
    .cur_priv_super(cur_priv_super), .supervisor_return(supervisor_return), .irq_accept(irq_accept),
    .irq_request(irq_request), .irq_cause(irq_cause), .redirect_ff(redirect_ff),
    .redirect_pc_ff(redirect_pc_ff), .priv_super_ff(priv_super_ff));
  stcu_pipe_model PM (.ref_clk(ref_clk), .sys_rst(sys_rst), .take_en(take_en),
    .irq_request(irq_request), .irq_accept(irq_accept));
  task chk(input [31:0] nm, input [63:0] s, e);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("Error %0s exp %h seen %h", nm, e, s);
    end
  end
  endtask
  task tick;
  begin
    @(posedge ref_clk);
    #2;
  end
  endtask
  // strobe dropped a cycle before the next write may raise it
  task wr(input [11:0] a, input [63:0] d);
  begin
    csr_addr = a;
    csr_wdata = d;
    csr_wr = 1;
    tick;
    csr_wr = 0;
    tick;
  end
  endtask
  task rc(input [11:0] a, input [63:0] e);
  begin
    csr_addr = a;
    #1 chk("csr", csr_rdata, e);
    tick;
  end
  endtask
  task wredir;
  begin
    take_en = 1;
    for (i = 0; i < 20 && redirect_ff !== 1'b1; i = i + 1)
      tick;
    take_en = 0;
    n_fail = n_fail + (i == 20);
    if (i == 20)
      results;
  end
  endtask
  task results;
  begin
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task t_exc;
  begin
    wr(12'h105, 64'h1001);
    for (c = 0; c < 17; c = c + 1)
    begin
      exc_code = c;
      exc_valid = 1;
      tick;
      exc_valid = 0;
      chk("pc", redirect_pc_ff, 64'h1000);
      rc(12'h141, 64'h4000);
      rc(12'h142, (c == 4 || c == 14 || c > 15 || (c > 8 && c < 12)) ? 2 : c);
      rc(12'h100, 64'h100);
    end
  end
  endtask
  task t_irq;
  begin
    wr(12'h104, 64'h222);
    wr(12'h144, 64'hFFFFFFFFFFFFFFFF);
    timer_irq_in = 1;
    external_irq_in = 1;
    wr(12'h100, 64'h2);
    rc(12'h144, 64'h222);
    chk("hit", csr_hit, 1);
    chk("cau", irq_cause, 63'h9);
    wredir;
    chk("pc", redirect_pc_ff, 64'h1024);
    rc(12'h142, 64'h8000000000000009);
    rc(12'h100, 64'h120);
    wr(12'h100, 64'h22);
    chk("req", irq_request, 1);
    csr_addr = 12'h141;
    supervisor_return = 1;
    tick;
    supervisor_return = 0;
    chk("pc", redirect_pc_ff, 64'h4000);
    chk("priv", priv_super_ff, 0);
    rc(12'h100, 64'h22);
    external_irq_in = 0;
    wredir;
    rc(12'h142, 64'h8000000000000001);
    rc(12'h100, 64'h20);
    wr(12'h144, 0);
    wr(12'h100, 64'h2);
    wredir;
    chk("pc", redirect_pc_ff, 64'h1014);
    wr(12'h104, 0);
    wr(12'h100, 64'h2);
    chk("req", irq_request, 0);
    wr(12'h105, 64'h2002);
    rc(12'h105, 64'h2001);
    rc(12'h7FF, 0);
    chk("hit", csr_hit, 0);
  end
  endtask
  initial
  begin
    tick;
    tick;
    sys_rst = 0;
    t_exc;
    t_irq;
    results;
  end
endmodule
